// ---- src/wtu_pkg.sv ----
package wtu_pkg;
  // Register byte offsets
  localparam logic [7:0] RESET_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] FUSE_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0C;
  localparam logic [7:0] CNT_OFS  = 8'h10;
  // Reset-control register bits
  localparam int RC_SWON_BIT = 5;
  localparam int RC_TO_BIT   = 4;
  localparam int RC_SLP_BIT  = 3;
  localparam int RC_IDL_BIT  = 2;
  // Interrupt status and mask bits
  localparam int ST_TO_BIT    = 0;
  localparam int ST_EARLY_BIT = 1;
  localparam int ST_W         = 2;
  // Prescaler ratios and postscaler span
  localparam int PRE_DIV_SHORT = 32;
  localparam int PRE_DIV_LONG  = 128;
  localparam logic [4:0] PRE_BITS_SHORT = 5'($clog2(PRE_DIV_SHORT));
  localparam logic [4:0] PRE_BITS_LONG  = 5'($clog2(PRE_DIV_LONG));
  localparam int POST_MAX_BITS = 15;
  localparam int CNT_W = $clog2(PRE_DIV_LONG) + POST_MAX_BITS;
  // Fuse register reset value: 1:32768, div 32, non-window, software enable
  localparam logic [7:0] FUSE_RST = 8'h4F;

  // Watchdog fuse register layout
  typedef struct packed {
    logic       force_on;
    logic       window_off;
    logic       rsvd;
    logic       prescale_sel;
    logic [3:0] postscale;
  } wtu_fuse_s;

  // Core events, one-cycle pulses
  typedef struct packed {
    logic clear_instr;
    logic power_save;
    logic save_sleep;
    logic exit_save;
    logic clk_switch_done;
  } wtu_cpu_evt_s;

  typedef enum {WTU_RUN, WTU_SLEEP, WTU_IDLE} wtu_mode_e;
endpackage

// ---- src/wtu_watchdog.sv ----
`timescale 1ns/10ps
module wtu_watchdog (
  input  wire logic                  CLK_I,
  input  wire logic                  RST_B_I,
  input  wire logic                  CE_I,
  input  wire logic                  LOW_POWER_RC_CLOCK_CLK_I,
  input  wire wtu_pkg::wtu_cpu_evt_s CPU_EVT_I,
  input  wire logic [7:0]            AVS_ADDRESS_I,
  input  wire logic                  AVS_READ_I,
  input  wire logic                  AVS_WRITE_I,
  input  wire logic [31:0]           AVS_WRITEDATA_I,
  input  wire logic [3:0]            AVS_BYTEENABLE_I,
  output logic [31:0]                AVS_READDATA_O,
  output logic                       AVS_WAITREQUEST_O,
  output logic                       RC_ENABLE_O,
  output logic                       WDT_RESET_O,
  output logic                       WAKE_O,
  output logic                       IRQ_O
);
  import wtu_pkg::*;

  logic                rc_s1;
  logic                rc_s2;
  logic                rc_s3;
  logic                sw_on;
  logic                to_flag;
  logic                slp_flag;
  logic                idl_flag;
  logic [ST_W-1:0]     stat;
  logic [ST_W-1:0]     mask;
  logic [CNT_W-1:0]    cnt;
  wtu_fuse_s           fuse;
  wtu_mode_e           mode;
  wtu_mode_e           next_mode;
  logic                running;
  logic                tick;
  logic                in_run;
  logic [4:0]          shamt;
  logic [CNT_W:0]      period;
  logic [CNT_W-1:0]    last;
  logic [CNT_W-1:0]    win_start;
  logic                timeout;
  logic                early;
  logic                clr_run;
  logic                ps_enter;
  logic                ps_exit;
  logic                cnt_clr;
  logic                req;
  logic                acc;
  logic                wr;
  logic                sel_reset_control_reg;
  logic                sel_fuse;
  logic                sel_stat;
  logic                sel_mask;
  logic                sel_cnt;
  logic [31:0]         rd_mux;
  logic [ST_W-1:0]     st_ev;
  logic [ST_W-1:0]     next_stat;

  // Enable, from fuse or software
  assign running = fuse.force_on | sw_on;
  assign in_run  = (mode == WTU_RUN);

  // RC edge from synchroniser output only
  assign tick = rc_s2 & ~rc_s3;

  // Period of prescaler times postscaler, in RC ticks
  assign shamt = (fuse.prescale_sel ? PRE_BITS_LONG : PRE_BITS_SHORT)
               + {1'b0, fuse.postscale};
  assign period    = (CNT_W+1)'(1) << shamt;
  assign last      = CNT_W'(period - (CNT_W+1)'(1));
  assign win_start = CNT_W'(period - (period >> 2));

  // Event decode
  assign timeout  = running & tick & (cnt >= last);
  assign clr_run  = CPU_EVT_I.clear_instr & in_run;
  assign early    = clr_run & running & ~fuse.window_off
                  & (cnt < win_start);
  assign ps_enter = CPU_EVT_I.power_save & in_run;
  assign ps_exit  = ~in_run & (CPU_EVT_I.exit_save | timeout);
  assign cnt_clr  = clr_run | ps_enter | ps_exit | early
                  | CPU_EVT_I.clk_switch_done | ~running
                  | (timeout & in_run);

  // Mode sequencing
  always_comb begin
    next_mode = mode;
    unique case (mode)
      WTU_RUN: begin
        if (ps_enter) begin
          next_mode = CPU_EVT_I.save_sleep ? WTU_SLEEP : WTU_IDLE;
        end
      end
      WTU_SLEEP, WTU_IDLE: begin
        if (ps_exit) begin
          next_mode = WTU_RUN;
        end
      end
    endcase
  end

  // Bus decode
  assign req      = AVS_READ_I | AVS_WRITE_I;
  assign acc      = req & ~AVS_WAITREQUEST_O;
  assign wr       = acc & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
  assign sel_reset_control_reg = (AVS_ADDRESS_I == RESET_CONTROL_REG_OFS);
  assign sel_fuse = (AVS_ADDRESS_I == FUSE_OFS);
  assign sel_stat = (AVS_ADDRESS_I == STAT_OFS);
  assign sel_mask = (AVS_ADDRESS_I == MASK_OFS);
  assign sel_cnt  = (AVS_ADDRESS_I == CNT_OFS);
  assign rd_mux   = sel_reset_control_reg ? {26'h0, sw_on, to_flag, slp_flag, idl_flag, 2'h0}
                  : sel_fuse ? {24'h0, fuse}
                  : sel_stat ? {30'h0, stat}
                  : sel_mask ? {30'h0, mask}
                  : sel_cnt  ? {10'h0, cnt}
                  : 32'h0;

  // Interrupt events, set beats write-one clear
  assign st_ev     = {early, timeout};
  assign next_stat = (stat & ~((wr & sel_stat) ? AVS_WRITEDATA_I[ST_W-1:0]
                                               : {ST_W{1'b0}})) | st_ev;

  // RC input synchroniser
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else if (CE_I) begin
      rc_s1 <= LOW_POWER_RC_CLOCK_CLK_I;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  // Combined prescaler and postscaler count
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cnt  <= '0;
      mode <= WTU_RUN;
    end else if (CE_I) begin
      mode <= next_mode;
      if (cnt_clr) begin
        cnt <= '0;
      end else if (running & tick) begin
        cnt <= cnt + CNT_W'(1);
      end
    end
  end

  // Reset-control bits
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sw_on    <= 1'b0;
      to_flag  <= 1'b0;
      slp_flag <= 1'b0;
      idl_flag <= 1'b0;
    end else if (CE_I) begin
      if (wr & sel_reset_control_reg) begin
        sw_on <= AVS_WRITEDATA_I[RC_SWON_BIT];
      end
      to_flag  <= timeout | (to_flag & ~(wr & sel_reset_control_reg
                  & AVS_WRITEDATA_I[RC_TO_BIT]));
      slp_flag <= (ps_enter & CPU_EVT_I.save_sleep) | (slp_flag
                  & ~(wr & sel_reset_control_reg & AVS_WRITEDATA_I[RC_SLP_BIT]));
      idl_flag <= (ps_enter & ~CPU_EVT_I.save_sleep) | (idl_flag
                  & ~(wr & sel_reset_control_reg & AVS_WRITEDATA_I[RC_IDL_BIT]));
    end
  end

  // Fuse, status and mask registers
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fuse <= wtu_fuse_s'(FUSE_RST);
      stat <= '0;
      mask <= '0;
    end else if (CE_I) begin
      stat <= next_stat;
      if (wr & sel_fuse) begin
        fuse <= wtu_fuse_s'(AVS_WRITEDATA_I[7:0]);
      end
      if (wr & sel_mask) begin
        mask <= AVS_WRITEDATA_I[ST_W-1:0];
      end
    end
  end

  // Bus answer: one wait state per access
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0;
    end else if (CE_I) begin
      AVS_WAITREQUEST_O <= ~(req & AVS_WAITREQUEST_O);
      if (req & AVS_WAITREQUEST_O) begin
        AVS_READDATA_O <= rd_mux;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RC_ENABLE_O <= 1'b0;
      WDT_RESET_O <= 1'b0;
      WAKE_O      <= 1'b0;
      IRQ_O       <= 1'b0;
    end else if (CE_I) begin
      RC_ENABLE_O <= running;
      WDT_RESET_O <= (timeout & in_run) | early;
      WAKE_O      <= timeout & ~in_run;
      IRQ_O       <= |(next_stat & mask);
    end
  end

  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  rc_enable_a: assert property (CE_I ##1 CE_I |-> RC_ENABLE_O == $past(running))
    else $error("RC enable does not follow watchdog enable");
  force_run_a: assert property (fuse.force_on |-> running)
    else $error("Force-on fuse did not keep watchdog running");
  sw_run_a: assert property (!fuse.force_on |-> running == sw_on)
    else $error("Software enable does not gate watchdog");
  short_period_a: assert property (timeout && !fuse.prescale_sel && fuse.postscale == 4'h0
    |-> cnt == 22'd31)
    else $error("Divide-by-32 base period wrong");
  long_period_a: assert property (timeout && fuse.prescale_sel && fuse.postscale == 4'hF
    |-> cnt == 22'h3FFFFF)
    else $error("Longest period wrong");
  clr_instr_a: assert property (CE_I && clr_run |=> cnt == 22'h0)
    else $error("Clear instruction did not clear count");
  clk_switch_a: assert property (CE_I && CPU_EVT_I.clk_switch_done |=> cnt == 22'h0)
    else $error("Clock switch did not clear count");
  save_entry_a: assert property (CE_I && ps_enter |=> cnt == 22'h0 && mode != WTU_RUN)
    else $error("Power-save entry mishandled");
  save_count_a: assert property (CE_I && tick && running && !in_run && !timeout
    && !CPU_EVT_I.exit_save && !CPU_EVT_I.clk_switch_done
    |=> cnt == $past(cnt) + 22'h1)
    else $error("Counter stalled in power save");
  wake_a: assert property (CE_I && timeout && !in_run
    |=> WAKE_O && !WDT_RESET_O && mode == WTU_RUN)
    else $error("Timeout in power save did not wake");
  flag_a: assert property (CE_I && timeout |=> to_flag)
    else $error("Timeout flag not set");
  run_reset_a: assert property (CE_I && timeout && in_run |=> WDT_RESET_O)
    else $error("Timeout in run gave no reset");
  early_clr_a: assert property (CE_I && clr_run && running && !fuse.window_off
    && cnt < win_start |=> WDT_RESET_O)
    else $error("Early clear in window mode gave no reset");
  late_clr_a: assert property (CE_I && clr_run && (fuse.window_off || cnt >= win_start)
    && !timeout |=> !WDT_RESET_O)
    else $error("Permitted clear caused reset");

  run_timeout_c: cover property (timeout && in_run);
  sleep_wake_c: cover property (mode == WTU_SLEEP ##[1:1000] WAKE_O);
  early_clear_c: cover property (early);
  irq_c: cover property ($rose(IRQ_O));
endmodule

// ---- tb/wtu_watchdog_tb_top.sv ----
`timescale 1ns/10ps
module wtu_watchdog_tb_top;
  import wtu_pkg::*;
  localparam int TICK = 8; // Clock cycles per RC tick
  logic         clk   = 1'b0;
  logic         rst_b = 1'b0;
  logic         low_power_rc_clock  = 1'b0;
  logic [7:0]   addr  = 8'h00;
  logic         rd    = 1'b0;
  logic         wr    = 1'b0;
  logic [31:0]  wdata = 32'h0;
  wtu_cpu_evt_s evt   = '0;
  logic [31:0]  rdata;
  logic [31:0]  q;
  logic         waitreq;
  logic         rc_en;
  logic         wdt_rst;
  logic         wake;
  logic         irq;
  int           n_fail = 0;
  int           num_checks = 0;
  int           n_rst = 0;
  int           n_wake = 0;
  int           lp = 0;
  int           n;
  int           s;
  logic [7:0]   fz[3] = '{8'h40, 8'h41, 8'h50};
  int           pt[3] = '{32, 64, 128};
  logic [4:0]   ev[4] = '{5'h01, 5'h10, 5'h08, 5'h02};

  always #5 clk = ~clk;
  // Fast stand-in for the RC clock, one tick every TICK cycles
  always @(posedge clk) begin
    lp <= (lp == TICK - 1) ? 0 : lp + 1;
    low_power_rc_clock <= (lp < TICK / 2);
  end
  // Count reset and wake pulses
  always @(posedge clk) begin
    if (wdt_rst === 1'b1) n_rst <= n_rst + 1;
    if (wake === 1'b1) n_wake <= n_wake + 1;
  end

  wtu_watchdog dut_u (
    .CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .LOW_POWER_RC_CLOCK_CLK_I(low_power_rc_clock), .CPU_EVT_I(evt),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .RC_ENABLE_O(rc_en), .WDT_RESET_O(wdt_rst), .WAKE_O(wake), .IRQ_O(irq));

  // One bus access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  // One-cycle core event pulse
  task automatic pulse(input logic [4:0] e);
    @(posedge clk);
    evt <= wtu_cpu_evt_s'(e);
    @(posedge clk);
    evt <= '0;
  endtask

  // Wait for a wake or reset pulse, n gets the cycles spent
  task automatic wait_ev(input logic wk, input int lim);
    int st;
    st = wk ? n_wake : n_rst;
    n = 0;
    while ((wk ? n_wake : n_rst) == st && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #200000;
    n_fail++;
    results;
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h0);
    bus(0, FUSE_OFS, 0); chk32(q, 32'h4F);
    bus(0, 8'h20, 0); chk32(q, 32'h0);
    chk1(rc_en, 1'b0);
    $display("test reset done");
    // Run-mode timeout period per prescale and postscale setting
    bus(1, MASK_OFS, 1);
    bus(1, RESET_CONTROL_REG_OFS, 32'h20);
    for (int i = 0; i < 3; i++) begin
      bus(1, FUSE_OFS, {24'h0, fz[i]});
      pulse(5'h10);
      wait_ev(0, 2000);
      s = pt[i] * TICK;
      chk1(n inside {[s - 12:s + 12]}, 1'b1);
    end
    chk1(rc_en, 1'b1);
    chk1(irq, 1'b1);
    repeat (20) @(posedge clk);
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h30);
    bus(0, STAT_OFS, 0); chk32(q, 32'h1);
    bus(1, STAT_OFS, 1);
    bus(1, RESET_CONTROL_REG_OFS, 32'h30);
    @(negedge clk);
    chk1(irq, 1'b0);
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h20);
    $display("test timeout done");
    // Counter clears on switch, clear, idle entry and exit; counts in idle
    pulse(5'h10);
    for (int i = 0; i < 4; i++) begin
      repeat (100) @(posedge clk);
      bus(0, CNT_OFS, 0); chk1(q >= 8, 1'b1);
      pulse(ev[i]);
      bus(0, CNT_OFS, 0); chk1(q < 2, 1'b1);
    end
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h24);
    $display("test clears done");
    // Timeout in sleep wakes the core without a reset
    bus(1, FUSE_OFS, 32'h40);
    pulse(5'h0C);
    s = n_rst;
    wait_ev(1, 400);
    chk1(n >= 32 * TICK - 12 && n <= 32 * TICK + 12, 1'b1);
    chk32(32'(n_rst), 32'(s));
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h3C);
    bus(1, RESET_CONTROL_REG_OFS, 32'h3C);
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h20);
    $display("test sleep done");
    // Window mode: early clear resets, late clear does not
    bus(1, STAT_OFS, 3);
    bus(1, FUSE_OFS, 0);
    pulse(5'h10);
    wait_ev(0, 4);
    chk1(n < 4, 1'b1);
    bus(0, STAT_OFS, 0); chk32(q, 32'h2);
    chk1(irq, 1'b0);
    repeat (26 * TICK) @(posedge clk);
    pulse(5'h10);
    wait_ev(0, 6);
    chk1(n == 6, 1'b1);
    $display("test window done");
    // Enable sources
    bus(1, RESET_CONTROL_REG_OFS, 0);
    bus(1, FUSE_OFS, 32'hC0);
    repeat (2) @(negedge clk);
    chk1(rc_en, 1'b1);
    bus(1, FUSE_OFS, 32'h40);
    repeat (2) @(negedge clk);
    chk1(rc_en, 1'b0);
    bus(0, CNT_OFS, 0); chk32(q, 32'h0);
    // Device reset drops the software enable
    bus(1, RESET_CONTROL_REG_OFS, 32'h20);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    bus(0, RESET_CONTROL_REG_OFS, 0); chk32(q, 32'h0);
    chk1(rc_en, 1'b0);
    $display("test enable done");
    results;
  end
endmodule
